// *** apq_params.svh ***
// Constants for the asynchronous packet confirmation queue block.
// Assumes inclusion by the package, the design file, the monitor and the bench.
// Contract
// [RULE_01] After each sent packet build a confirmation, queue it, no register
// [RULE_02] Exactly one confirmation per packet written to a transmit queue
// [RULE_03] Codes: 0 no ack, 1 broadcast or complete, 2 ack pending
// [RULE_04] Code 4 when retry limit exceeded on non-broadcast packet
// [RULE_05] Code D data error, E type error; other codes never produced
// [RULE_06] Response queue still sends while a request awaits its response
// [RULE_07] Receiver and queues reset on power-on and every bus reset; bus reset here clears only the receive queues, transmit queues kept
// [RULE_08] Software receiver reset bit self-clears only when receiver idle
// [RULE_09] Flag rising with enable set asserts active-low interrupt
// [RULE_10] Write one acknowledges; interrupt releases unless others pending
// [RULE_11] Flags read latched status cleared by write one, not raw condition
// [RULE_12] Driver reads queued packets ahead of a confirmation first
// [RULE_13] Optional memory status: four bits per queue plus idle bits; memory status here holds only the four bits per queue
// [RULE_14] Reading receive queue returns and removes oldest quadlet
// [RULE_15] Two write locations per transmit queue; last one completes packet
// [RULE_16] Confirmations written after final outcome, in order of outcome
`ifndef APQ_PARAMS_SVH
`define APQ_PARAMS_SVH

// =========================================================
// Register byte offsets
`define APQ_CTRL_OFS 12'h000
`define APQ_IRQ_STATUS_OFS 12'h004
`define APQ_IRQ_MASK_OFS 12'h008
`define APQ_MEM_STATUS_OFS 12'h00C
`define APQ_REQ_TX_OFS 12'h010
`define APQ_REQ_TX_LAST_OFS 12'h014
`define APQ_RSP_TX_OFS 12'h018
`define APQ_RSP_TX_LAST_OFS 12'h01C
`define APQ_REQ_RX_OFS 12'h020
`define APQ_RSP_RX_OFS 12'h024

// =========================================================
// Field positions
`define APQ_CTRL_RX_RESET_BIT 0
`define APQ_IRQ_REQ_FULL_BIT 0
`define APQ_IRQ_RSP_FULL_BIT 1
`define APQ_IRQ_REQ_IDLE_BIT 2
`define APQ_IRQ_RSP_IDLE_BIT 3
`define APQ_IRQ_WIDTH 4

// =========================================================
// Confirmation codes
`define APQ_CONF_NO_ACK 4'h0
`define APQ_CONF_COMPLETE 4'h1
`define APQ_CONF_PENDING 4'h2
`define APQ_CONF_RETRY 4'h4
`define APQ_CONF_DATA_ERR 4'hD
`define APQ_CONF_TYPE_ERR 4'hE

// =========================================================
// Queue geometry and reset values
`define APQ_QADDR_W 4
`define APQ_QDEPTH 16
`define APQ_CTRL_RESET 32'h00000000
`define APQ_MASK_RESET 4'h0

`endif

// *** apq_pkg.sv ***
// Types for the asynchronous packet confirmation queue block.
// Assumes apq_params.svh is on the include path.
`include "apq_params.svh"
package apq_pkg;
  // Outcome reported by the link transmitter
  typedef enum logic [2:0] {
    OUT_NO_ACK = 3'h0,
    OUT_COMPLETE = 3'h1,
    OUT_PENDING = 3'h2,
    OUT_RETRY = 3'h3,
    OUT_DATA_ERR = 3'h4,
    OUT_TYPE_ERR = 3'h5
  } outcome_t;

  // Transmit side state
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SEND = 3'b010,
    TX_CONF = 3'b100
  } tx_state_t;
endpackage : apq_pkg

// *** async_packet_confirm_queue.sv ***
// Async packet queues: transmit queues, receive queues with confirmations,
// receiver reset and interrupt flags behind an APB slave.
// Assumes a link transmitter and receiver on the same clock.
`timescale 1ns/10ps
`include "apq_params.svh"
module async_packet_confirm_queue (
  input wire logic clk,
  input wire logic resetn,
  input wire logic bus_reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic tx_valid,
  output logic tx_is_rsp,
  output logic [31:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  input wire logic tx_done,
  input wire apq_pkg::outcome_t tx_outcome,
  input wire logic rx_valid,
  input wire logic rx_is_rsp,
  input wire logic [31:0] rx_data,
  input wire logic rx_busy,
  output logic rx_in_reset,
  output logic irq_n
);
  import apq_pkg::*;

  localparam int D = `APQ_QDEPTH;
  localparam int AW = `APQ_QADDR_W;

  // =========================================================
  // State
  typedef struct packed {
    logic [31:0] prdata;
    logic rx_reset;
    logic [`APQ_IRQ_WIDTH-1:0] status;
    logic [`APQ_IRQ_WIDTH-1:0] mask;
    logic [`APQ_IRQ_WIDTH-1:0] prev_cond;
    logic [1:0][AW:0] tx_wp;
    logic [1:0][AW:0] tx_rp;
    logic [1:0][AW:0] tx_pk;
    logic [1:0][AW:0] rx_wp;
    logic [1:0][AW:0] rx_rp;
    tx_state_t txs;
    logic cur_q;
    logic req_wait;
    logic [31:0] tx_data;
    logic ack;
  } state_t;

  state_t s;
  state_t next_s;
  logic [31:0] txmem [2][D];
  logic [32:0] tx_ctl_last [2][D];
  logic [31:0] rxmem [2][D];

  // Queue occupancy
  function automatic logic [AW:0] used(input logic [AW:0] w,
                                       input logic [AW:0] r);
    used = w - r;
  endfunction : used

  // [RULE_03] [RULE_04] Outcome to confirmation code
  function automatic logic [3:0] conf_code(input outcome_t o);
    case (o)
      OUT_NO_ACK: conf_code = `APQ_CONF_NO_ACK;
      OUT_COMPLETE: conf_code = `APQ_CONF_COMPLETE;
      OUT_PENDING: conf_code = `APQ_CONF_PENDING;
      OUT_RETRY: conf_code = `APQ_CONF_RETRY;
      OUT_DATA_ERR: conf_code = `APQ_CONF_DATA_ERR;
      OUT_TYPE_ERR: conf_code = `APQ_CONF_TYPE_ERR;
      default: conf_code = `APQ_CONF_DATA_ERR;
    endcase
  endfunction : conf_code

  logic acc;
  logic ld;
  logic wr;
  logic rd;
  logic [1:0] txw;
  logic [1:0] txw_last;
  logic [1:0] rxr;
  logic [1:0] rx_full;
  logic [1:0] rx_empty;
  logic [1:0] tx_full;
  logic [1:0] pkt_ready;
  logic [`APQ_IRQ_WIDTH-1:0] cond;
  logic rx_clear;
  logic conf_wr;
  logic rx_wr;
  logic rx_q;
  logic [31:0] rx_wdata;
  logic [15:0] mem_status;
  logic sel_q;

  // Bus decode; one wait state so read data stands at the ready edge
  assign acc = psel && penable && s.ack;
  assign ld = psel && penable && !pwrite && !s.ack;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign pready = s.ack;
  always_comb begin
    pslverr = 1'b0;
    case (paddr)
      `APQ_CTRL_OFS, `APQ_IRQ_STATUS_OFS, `APQ_IRQ_MASK_OFS,
      `APQ_MEM_STATUS_OFS, `APQ_REQ_RX_OFS, `APQ_RSP_RX_OFS,
      `APQ_REQ_TX_OFS, `APQ_REQ_TX_LAST_OFS, `APQ_RSP_TX_OFS,
      `APQ_RSP_TX_LAST_OFS: pslverr = 1'b0;
      default: pslverr = acc;
    endcase
  end

  // Queue status and access strobes
  always_comb begin
    for (int q = 0; q < 2; q++) begin
      tx_full[q] = used(s.tx_wp[q], s.tx_rp[q]) == (AW+1)'(D);
      rx_full[q] = used(s.rx_wp[q], s.rx_rp[q]) == (AW+1)'(D);
      rx_empty[q] = s.rx_wp[q] == s.rx_rp[q];
      pkt_ready[q] = s.tx_pk[q] != s.tx_rp[q];
    end
    txw[0] = wr && !tx_full[0] && (paddr == `APQ_REQ_TX_OFS
                                   || paddr == `APQ_REQ_TX_LAST_OFS);
    txw[1] = wr && !tx_full[1] && (paddr == `APQ_RSP_TX_OFS
                                   || paddr == `APQ_RSP_TX_LAST_OFS);
    txw_last[0] = paddr == `APQ_REQ_TX_LAST_OFS;
    txw_last[1] = paddr == `APQ_RSP_TX_LAST_OFS;
    rxr[0] = rd && paddr == `APQ_REQ_RX_OFS && !rx_empty[0];
    rxr[1] = rd && paddr == `APQ_RSP_RX_OFS && !rx_empty[1];
  end

  // [RULE_13] Memory status bits
  always_comb begin
    for (int q = 0; q < 2; q++) begin
      mem_status[q*4+0] = used(s.rx_wp[q], s.rx_rp[q]) == (AW+1)'(D);
      mem_status[q*4+1] = used(s.rx_wp[q], s.rx_rp[q]) >= (AW+1)'(D - 1);
      mem_status[q*4+2] = used(s.rx_wp[q], s.rx_rp[q]) <= (AW+1)'(D - 5);
      mem_status[q*4+3] = rx_empty[q];
      mem_status[8+q*4+0] = tx_full[q];
      mem_status[8+q*4+1] = used(s.tx_wp[q], s.tx_rp[q])
                            >= (AW+1)'(D - 1);
      mem_status[8+q*4+2] = used(s.tx_wp[q], s.tx_rp[q])
                            <= (AW+1)'(D - 5);
      mem_status[8+q*4+3] = s.tx_wp[q] == s.tx_rp[q];
    end
  end

  // [RULE_01] Confirmation takes queue write port over received data
  assign conf_wr = s.txs == TX_CONF && tx_done;
  assign rx_q = conf_wr ? s.cur_q : rx_is_rsp;
  assign rx_wr = (conf_wr || (rx_valid && !s.rx_reset))
                 && !rx_full[rx_q];
  // [RULE_05] Only defined codes in the low nibble
  assign rx_wdata = conf_wr ? {28'h0000000, conf_code(tx_outcome)}
                            : rx_data;

  // [RULE_07] Receiver cleared on power-on, bus reset or control bit
  assign rx_clear = bus_reset || s.rx_reset;

  // Raw full and idle conditions
  assign cond = {s.txs == TX_IDLE && !pkt_ready[1],
                 s.txs == TX_IDLE && !pkt_ready[0],
                 rx_full[1], rx_full[0]};

  assign sel_q = pkt_ready[1] ? 1'b1 : 1'b0;

  // Next state
  always_comb begin
    next_s = s;
    next_s.prdata = s.prdata;
    next_s.prev_cond = cond;
    next_s.ack = psel && penable && !s.ack;
    // Register reads, loaded in the wait state
    if (ld) begin
      case (paddr)
        `APQ_CTRL_OFS: next_s.prdata = {31'h0, s.rx_reset};
        // [RULE_11] Latched status returned
        `APQ_IRQ_STATUS_OFS: next_s.prdata = {28'h0, s.status};
        `APQ_IRQ_MASK_OFS: next_s.prdata = {28'h0, s.mask};
        `APQ_MEM_STATUS_OFS: next_s.prdata = {16'h0, mem_status};
        // [RULE_14] Read pops oldest quadlet
        `APQ_REQ_RX_OFS: next_s.prdata = rxmem[0][s.rx_rp[0][AW-1:0]];
        `APQ_RSP_RX_OFS: next_s.prdata = rxmem[1][s.rx_rp[1][AW-1:0]];
        default: next_s.prdata = 32'h00000000;
      endcase
    end
    // [RULE_09] Rising condition latches status; set beats clear
    // [RULE_10] Write one acknowledges
    next_s.status = s.status;
    if (wr && paddr == `APQ_IRQ_STATUS_OFS)
      next_s.status = s.status & ~pwdata[`APQ_IRQ_WIDTH-1:0];
    next_s.status = next_s.status | (cond & ~s.prev_cond);
    if (wr && paddr == `APQ_IRQ_MASK_OFS)
      next_s.mask = pwdata[`APQ_IRQ_WIDTH-1:0];
    // [RULE_08] Self-clearing receiver reset, held while receiver busy
    if (wr && paddr == `APQ_CTRL_OFS && pwdata[`APQ_CTRL_RX_RESET_BIT])
      next_s.rx_reset = 1'b1;
    else if (s.rx_reset && !rx_busy)
      next_s.rx_reset = 1'b0;
    // [RULE_15] Transmit writes; last location marks packet complete
    for (int q = 0; q < 2; q++) begin
      if (txw[q]) begin
        next_s.tx_wp[q] = s.tx_wp[q] + 1'b1;
        if (txw_last[q])
          next_s.tx_pk[q] = s.tx_wp[q] + 1'b1;
      end
      if (rxr[q])
        next_s.rx_rp[q] = s.rx_rp[q] + 1'b1;
    end
    // Receive queue write
    if (rx_wr)
      next_s.rx_wp[rx_q] = s.rx_wp[rx_q] + 1'b1;
    // Transmit sequencer
    case (s.txs)
      TX_IDLE: begin
        // [RULE_06] Responses go even while a request waits
        if (pkt_ready[1] || (pkt_ready[0] && !s.req_wait)) begin
          next_s.cur_q = sel_q;
          next_s.txs = TX_SEND;
        end
      end
      TX_SEND: begin
        if (tx_ready) begin
          next_s.tx_rp[s.cur_q] = s.tx_rp[s.cur_q] + 1'b1;
          if (tx_ctl_last[s.cur_q][s.tx_rp[s.cur_q][AW-1:0]][32])
            next_s.txs = TX_CONF;
        end
      end
      TX_CONF: begin
        // [RULE_16] Wait for final outcome; [RULE_02] one per packet
        if (tx_done && !rx_full[s.cur_q]) begin
          next_s.txs = TX_IDLE;
          if (!s.cur_q)
            next_s.req_wait = tx_outcome == OUT_PENDING;
        end
      end
      default: next_s.txs = TX_IDLE;
    endcase
    if (rx_valid && rx_is_rsp && !s.rx_reset)
      next_s.req_wait = 1'b0;
    if (rx_clear) begin
      for (int q = 0; q < 2; q++) begin
        next_s.rx_wp[q] = '0;
        next_s.rx_rp[q] = '0;
      end
    end
  end

  // Registered state
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s <= '0;
      s.txs <= TX_IDLE;
      s.mask <= `APQ_MASK_RESET;
      s.rx_reset <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Queue memories
  always_ff @(posedge clk) begin
    for (int q = 0; q < 2; q++) begin
      if (txw[q]) begin
        txmem[q][s.tx_wp[q][AW-1:0]] <= pwdata;
        tx_ctl_last[q][s.tx_wp[q][AW-1:0]] <= {txw_last[q], pwdata};
      end
    end
    if (rx_wr)
      rxmem[rx_q][s.rx_wp[rx_q][AW-1:0]] <= rx_wdata;
  end

  // Outputs
  assign prdata = s.prdata;
  assign tx_valid = s.txs == TX_SEND;
  assign tx_is_rsp = s.cur_q;
  assign tx_data = txmem[s.cur_q][s.tx_rp[s.cur_q][AW-1:0]];
  assign tx_last = tx_ctl_last[s.cur_q][s.tx_rp[s.cur_q][AW-1:0]][32];
  assign rx_in_reset = s.rx_reset;
  // [RULE_10] Low while any unmasked flag pends
  assign irq_n = ~|(s.status & s.mask);
endmodule : async_packet_confirm_queue

// *** apq_monitor.sv ***
// Port checker for the async packet confirmation queue.
// Assumes apq_params.svh on the include path; bound below.
`timescale 1ns/10ps
`include "apq_params.svh"
module apq_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire logic bus_reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_valid,
  input wire logic [31:0] tx_data,
  input wire logic tx_ready,
  input wire logic tx_done,
  input wire logic rx_valid,
  input wire logic rx_busy,
  input wire logic rx_in_reset,
  input wire logic irq_n
);
  // ==========================================
  // Assertions
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Status acknowledge access
  sequence ack_wr;
    psel && penable && pready && pwrite && paddr == `APQ_IRQ_STATUS_OFS;
  endsequence
  // Cycle with no flag event
  sequence quiet;
    !rx_valid && !tx_done && !tx_ready && !bus_reset;
  endsequence
  reset_vals_a: assert property ($rose(resetn) |-> irq_n && !tx_valid)
    else $error("outputs not idle after reset");
  rx_hold_a: assert property (rx_in_reset && rx_busy |=> rx_in_reset)
    else $error("receiver reset ended mid packet");
  rx_clear_a: assert property (rx_in_reset && !rx_busy && !psel
    && !bus_reset |-> ##[1:2] !rx_in_reset) else $error("reset stuck");
  tx_hold_a: assert property (tx_valid && !tx_ready && !bus_reset
    |=> tx_valid && $stable(tx_data)) else $error("quadlet dropped");
  mask_off_a: assert property (psel && penable && pready && pwrite
    && paddr == `APQ_IRQ_MASK_OFS && pwdata[3:0] == 4'h0 |=> irq_n)
    else $error("irq with all masked");
  irq_quiet_a: assert property (quiet ##1 (irq_n && !psel && quiet)
    |=> irq_n)
    else $error("irq without event");
  irq_ack_a: assert property (ack_wr ##0 quiet ##0 pwdata[3:0] == 4'hF
    |=> irq_n) else $error("irq kept after ack");
  irq_hold_a: assert property (!irq_n && !psel && !bus_reset |=> !irq_n)
    else $error("irq dropped without ack");
  unmapped_err_a: assert property (psel && penable && pready
    && paddr[11:8] != 4'h0
    |-> pslverr) else $error("no error on unmapped access");
endmodule : apq_monitor
bind async_packet_confirm_queue apq_monitor apq_monitor_i (.*);

// *** link_model.sv ***
// Link transmitter model: takes quadlets, reports an outcome.
// Assumes the block's clock; stall and outcome come from the bench.
`timescale 1ns/10ps
module link_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tx_valid,
  input wire logic tx_last,
  input wire logic slow,
  input wire apq_pkg::outcome_t oc,
  output logic tx_ready,
  output logic tx_done,
  output apq_pkg::outcome_t tx_outcome
);
  import apq_pkg::*;
  logic ph;
  // Take every cycle, or every other one when stalling
  assign tx_ready = tx_valid && (!slow || ph);
  always_ff @(posedge clk) begin
    ph <= resetn ? !ph : 1'b0;
    tx_done <= resetn && tx_ready && tx_last;
    tx_outcome <= outcome_t'(tx_ready && tx_last ? oc : ~oc);
  end
endmodule : link_model

// *** async_packet_confirm_queue_bench.sv ***
// Self-checking bench for the async packet confirmation queue.
// Assumes the link model and the monitor are compiled first.
`timescale 1ns/10ps
`include "apq_params.svh"
module async_packet_confirm_queue_bench;
  import apq_pkg::*;
  logic clk, resetn, bus_reset, psel, penable, pwrite, pready, pslverr;
  logic tx_valid, tx_is_rsp, tx_last, tx_ready, tx_done, rx_valid;
  logic rx_is_rsp, rx_busy, rx_in_reset, irq_n, slow, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, tx_data, rx_data, r;
  outcome_t tx_outcome, oc;
  int error_cnt = 0;
  int n_tests = 0;
  async_packet_confirm_queue async_packet_confirm_queue_i (.clk(clk),
    .resetn(resetn), .bus_reset(bus_reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_valid(tx_valid),
    .tx_is_rsp(tx_is_rsp), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready), .tx_done(tx_done), .tx_outcome(tx_outcome),
    .rx_valid(rx_valid), .rx_is_rsp(rx_is_rsp), .rx_data(rx_data),
    .rx_busy(rx_busy), .rx_in_reset(rx_in_reset), .irq_n(irq_n));
  link_model link_model_i (.clk(clk), .resetn(resetn), .tx_valid(tx_valid),
    .tx_last(tx_last), .slow(slow), .oc(oc), .tx_ready(tx_ready),
    .tx_done(tx_done), .tx_outcome(tx_outcome));
  // ==========================================
  // Clock
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // APB transfer; data and error taken at the edge that sees pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    err = pslverr;
    r = prdata;
    psel <= 0;
    penable <= 0;
    chk(n < 50, 1);
    @(posedge clk);
  endtask : apb
  task automatic send(input logic rsp, input outcome_t o);
    int n = 0;
    oc <= o;
    apb(1, rsp ? `APQ_RSP_TX_OFS : `APQ_REQ_TX_OFS, 32'hA5);
    apb(1, rsp ? `APQ_RSP_TX_LAST_OFS : `APQ_REQ_TX_LAST_OFS, 32'h5A);
    while (tx_done !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk(n < 200, 1);
  endtask : send
  // ==========================================
  // Scenarios
  task automatic t_codes;
    outcome_t o[6] = '{OUT_NO_ACK, OUT_COMPLETE, OUT_PENDING, OUT_RETRY,
                       OUT_DATA_ERR, OUT_TYPE_ERR};
    logic [3:0] c[6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'hD, 4'hE};
    for (int i = 0; i < 6; i++) begin
      slow <= i[0];
      send(1, o[i]);
      apb(0, `APQ_RSP_RX_OFS, 0);
      chk(r, {28'h0, c[i]});
      apb(0, `APQ_MEM_STATUS_OFS, 0);
      chk(r[7], 1);
    end
  endtask : t_codes
  task automatic t_pass;
    send(0, OUT_PENDING);
    send(1, OUT_COMPLETE);
    apb(0, `APQ_RSP_RX_OFS, 0);
    chk(r, 32'h1);
    // request confirmation, pending code 2, read after the response's
    apb(0, `APQ_REQ_RX_OFS, 0);
    chk(r, 32'h2);
  endtask : t_pass
  task automatic t_irq;
    apb(1, `APQ_IRQ_STATUS_OFS, 32'hF);
    apb(1, `APQ_IRQ_MASK_OFS, 32'h1);
    for (int i = 0; i < `APQ_QDEPTH; i++) begin
      rx_valid <= 1;
      rx_data <= i;
      @(posedge clk);
    end
    rx_valid <= 0;
    rx_data <= 32'hFFFFFFFF;
    repeat (2) @(posedge clk);
    chk(irq_n, 0);
    for (int i = 0; i < `APQ_QDEPTH; i++) begin
      apb(0, `APQ_REQ_RX_OFS, 0);
      chk(r, i);
    end
    apb(0, `APQ_IRQ_STATUS_OFS, 0);
    chk(r[0], 1);
    apb(1, `APQ_IRQ_STATUS_OFS, 32'hF);
    chk(irq_n, 1);
    apb(1, `APQ_IRQ_MASK_OFS, 0);
  endtask : t_irq
  task automatic t_reset;
    rx_valid <= 1;
    @(posedge clk);
    rx_valid <= 0;
    bus_reset <= 1;
    @(posedge clk);
    bus_reset <= 0;
    apb(0, `APQ_MEM_STATUS_OFS, 0);
    chk(r[3], 1);
    rx_busy <= 1;
    apb(1, `APQ_CTRL_OFS, 1);
    repeat (4) @(posedge clk);
    chk(rx_in_reset, 1);
    rx_busy <= 0;
    repeat (3) @(posedge clk);
    chk(rx_in_reset, 0);
    apb(0, 12'h100, 0);
    chk(err, 1);
  endtask : t_reset
  task automatic conclude;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // ==========================================
  // Main sequence and watchdog
  initial begin
    {resetn, bus_reset, psel, penable, pwrite, rx_valid} <= 6'h00;
    {rx_is_rsp, rx_busy, slow} <= 3'h0;
    paddr <= 12'h000;
    {pwdata, rx_data} <= 64'h0;
    oc <= OUT_COMPLETE;
    repeat (10) @(posedge clk);
    resetn <= 1;
    @(posedge clk);
    t_codes;
    t_pass;
    t_irq;
    t_reset;
    conclude;
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    conclude;
  end
endmodule : async_packet_confirm_queue_bench
